// [dvr_defs.svh]
// constants of the digital volume ramp and clock monitor
// ============================================================
// How it works
// - status bit 5 flags a bit clock per frame ratio out of range
// - status bit 4 flags the PLL running above its permitted rate
// - status bit 3 shows PLL lock, always unlocked while PLL disabled
// - status bit 2 flags a missing bit clock
// - status bit 1 shows bit clock valid: ratio stable, 32 to 512
// - status bit 0: rate valid in auto mode, else rate mismatch
// - sample rate error flag rises even when errors are ignored
// - one 8-bit code for both channels, 0.5 dB per code, FF mutes
// - normal ramp down updates every 1, 2, 4 periods; 11 jumps
// - normal ramp down step is 4, 2, 1 or 0.5 dB
// - ramp up updates every 1, 2, 4 periods; 11 restores at once
// - ramp up step is 4, 2, 1 or 0.5 dB
// - bit clock error or power loss uses emergency rate; 11 mutes at once
// - emergency ramp down has its own 4, 2, 1, 0.5 dB step
`ifndef DVR_DEFS_SVH
`define DVR_DEFS_SVH

// ============================================================
// register offsets and reset values
`define DVR_OFS_CLKDET 8'h39
`define DVR_OFS_VOL 8'h4C
`define DVR_OFS_RAMP_N 8'h4E
`define DVR_OFS_RAMP_E 8'h4F
`define DVR_RST_VOL 8'h30
`define DVR_RST_RAMP_N 8'h33
`define DVR_RST_RAMP_E 8'h30

// ============================================================
// field positions
`define DVR_DN_RATE_MSB 7
`define DVR_DN_RATE_LSB 6
`define DVR_DN_STEP_MSB 5
`define DVR_DN_STEP_LSB 4
`define DVR_UP_RATE_MSB 3
`define DVR_UP_RATE_LSB 2
`define DVR_UP_STEP_MSB 1
`define DVR_UP_STEP_LSB 0
`define DVR_ST_BCK_RATE 5
`define DVR_ST_PLL_OVER 4
`define DVR_ST_PLL_LOCK 3
`define DVR_ST_BCK_MISS 2
`define DVR_ST_BCK_VALID 1
`define DVR_ST_FS 0

// ============================================================
// codes and limits
`define DVR_CODE_MUTE 8'hFF
`define DVR_RATE_INSTANT 2'h3
`define DVR_STEP_BASE 8'h08
`define DVR_RATIO_MIN 10'h020
`define DVR_RATIO_MAX 10'h200
`define DVR_SAMPLE_BITS 5'h18

// ============================================================
// timing: bit clock counted missing after this long without activity
`define DVR_MCLK_PERIOD_NS 25
`define DVR_BCK_MISS_NS 2000
`define DVR_BCK_MISS_CYC 8'((`DVR_BCK_MISS_NS + `DVR_MCLK_PERIOD_NS - 1) / `DVR_MCLK_PERIOD_NS)

`endif

// [dvr_pkg.sv]
// types of the digital volume ramp and clock monitor
package dvr_pkg;

	// ============================================================
	// ramp engine modes
	typedef enum logic [1:0] {
		RAMP_IDLE,
		RAMP_NORMAL,
		RAMP_EMERG
	} dvr_ramp_e;

	// ============================================================
	// state on the bit clock
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic fc_d;
		logic [9:0] cnt;
		logic [4:0] half;
		logic [23:0] shift;
		logic [23:0] left;
		logic [23:0] right;
		logic [9:0] ratio;
		logic tick_t;
		logic [2:0] act_cnt;
	} dvr_link_s;

	// ============================================================
	// state on the system clock
	typedef struct packed {
		logic [7:0] vol;
		logic [7:0] ramp_n;
		logic [7:0] ramp_e;
		logic [1:0] resv;
		logic [5:0] status;
		logic [7:0] rdata;
		logic [7:0] cur;
		dvr_ramp_e mode;
		logic [1:0] tick_cnt;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic tick_s1;
		logic tick_s2;
		logic tick_s3;
		logic act_s1;
		logic act_s2;
		logic act_s3;
		logic [7:0] miss_cnt;
		logic [9:0] ratio_cur;
		logic [9:0] ratio_prev;
		logic [23:0] out_l;
		logic [23:0] out_r;
		logic svalid;
	} dvr_core_s;

endpackage : dvr_pkg

// [dvr_volume_monitor.sv]
// digital volume ramp with bit clock monitor and status register
`timescale 1ns/1ps
`include "dvr_defs.svh"

module dvr_volume_monitor (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// register access port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// serial audio link
	input wire logic i_bit_clock,
	input wire logic i_frame_clock,
	input wire logic i_audio_data,
	// PLL and power pins, asynchronous
	input wire logic i_pll_lock,
	input wire logic i_pll_enable,
	input wire logic i_pll_overrate,
	input wire logic i_power_loss,
	// sample rate detector, same clock
	input wire logic i_fs_auto_mode,
	input wire logic i_fs_detect_valid,
	input wire logic i_fs_mismatch,
	// results
	output logic [7:0] o_volume_code,
	output logic o_ramp_active,
	output logic o_emergency,
	output logic [5:0] o_clock_fault_flags,
	output logic [23:0] o_left_sample,
	output logic [23:0] o_right_sample,
	output logic o_sample_valid
);

	dvr_pkg::dvr_link_s l_reg;
	dvr_pkg::dvr_link_s l_next;
	dvr_pkg::dvr_core_s c_reg;
	dvr_pkg::dvr_core_s c_next;

	// ============================================================
	// link domain: frame measure and sample capture
	// every rising bit clock edge is counted until the next frame start; the
	// count is the ratio and is held for a whole frame, so the core can
	// read it safely after the toggle crosses over
	logic frame_start;
	logic fc_edge;

	always_comb begin
		l_next = l_reg;
		frame_start = i_frame_clock & ~l_reg.fc_d;
		fc_edge = i_frame_clock ^ l_reg.fc_d;
		// reset enters this domain through two flops
		l_next.rst_s1 = i_sys_rst;
		l_next.rst_s2 = l_reg.rst_s1;
		l_next.fc_d = i_frame_clock;
		l_next.act_cnt = l_reg.act_cnt + 3'h1;
		// saturate so a very long frame still reads as too fast
		if (l_reg.cnt != 10'h3FF) begin
			l_next.cnt = l_reg.cnt + 10'h001;
		end
		if (frame_start) begin
			l_next.ratio = l_reg.cnt;
			l_next.cnt = 10'h001;
			l_next.tick_t = ~l_reg.tick_t;
		end
		// first bits after each frame clock edge form the sample
		if (fc_edge) begin
			l_next.half = 5'h01;
			l_next.shift = {23'h000000, i_audio_data};
			if (i_frame_clock) begin
				l_next.left = l_reg.shift;
			end else begin
				l_next.right = l_reg.shift;
			end
		end else if (l_reg.half != `DVR_SAMPLE_BITS) begin
			l_next.half = l_reg.half + 5'h01;
			l_next.shift = {l_reg.shift[22:0], i_audio_data};
		end
		if (l_reg.rst_s2) begin
			l_next.fc_d = 1'b0;
			l_next.cnt = 10'h000;
			l_next.half = 5'h00;
			l_next.shift = 24'h000000;
			l_next.left = 24'h000000;
			l_next.right = 24'h000000;
			l_next.ratio = 10'h000;
			l_next.tick_t = 1'b0;
			l_next.act_cnt = 3'h0;
		end
	end

	// link state registers; no reset here, the reset arrives synchronised
	always_ff @(posedge i_bit_clock) begin
		l_reg <= l_next;
	end

	// ============================================================
	// core domain helpers
	logic fs_tick;
	logic act_seen;
	logic missing;
	logic ratio_ok;
	logic bck_valid;
	logic emerg;
	logic down;
	logic [7:0] target;
	logic [1:0] rate;
	logic [1:0] step;
	logic [7:0] stepv;
	logic [7:0] diff;
	logic [1:0] limit;
	logic [7:0] rd_mux;

	always_comb begin
		c_next = c_reg;
		c_next.svalid = 1'b0;

		// pins and link toggles through two flops before use
		c_next.pin_s1 = {i_power_loss, i_pll_overrate, i_pll_enable, i_pll_lock};
		c_next.pin_s2 = c_reg.pin_s1;
		c_next.tick_s1 = l_reg.tick_t;
		c_next.tick_s2 = c_reg.tick_s1;
		c_next.tick_s3 = c_reg.tick_s2;
		c_next.act_s1 = l_reg.act_cnt[2];
		c_next.act_s2 = c_reg.act_s1;
		c_next.act_s3 = c_reg.act_s2;
		fs_tick = c_reg.tick_s2 ^ c_reg.tick_s3;
		act_seen = c_reg.act_s2 ^ c_reg.act_s3;

		// missing bit clock: no activity toggle for the timeout
		if (act_seen) begin
			c_next.miss_cnt = 8'h00;
		end else if (c_reg.miss_cnt != `DVR_BCK_MISS_CYC) begin
			c_next.miss_cnt = c_reg.miss_cnt + 8'h01;
		end
		missing = c_reg.miss_cnt == `DVR_BCK_MISS_CYC;

		// frame words are stable for half a frame after the tick
		if (fs_tick) begin
			c_next.ratio_cur = l_reg.ratio;
			c_next.ratio_prev = c_reg.ratio_cur;
			c_next.svalid = 1'b1;
			c_next.out_l = (c_reg.cur == `DVR_CODE_MUTE) ? 24'h000000 : l_reg.left;
			c_next.out_r = (c_reg.cur == `DVR_CODE_MUTE) ? 24'h000000 : l_reg.right;
		end
		ratio_ok = (c_reg.ratio_cur >= `DVR_RATIO_MIN) && (c_reg.ratio_cur <= `DVR_RATIO_MAX);
		bck_valid = ratio_ok && (c_reg.ratio_cur == c_reg.ratio_prev) && !missing;

		// live status word
		c_next.status[`DVR_ST_BCK_RATE] = missing | ~ratio_ok;
		c_next.status[`DVR_ST_PLL_OVER] = c_reg.pin_s2[2];
		c_next.status[`DVR_ST_PLL_LOCK] = c_reg.pin_s2[0] & c_reg.pin_s2[1];
		c_next.status[`DVR_ST_BCK_MISS] = missing;
		c_next.status[`DVR_ST_BCK_VALID] = bck_valid;
		// no ignore input gates this flag; it always reports the error
		c_next.status[`DVR_ST_FS] = i_fs_auto_mode ? i_fs_detect_valid : i_fs_mismatch;

		// ========================================================
		// ramp engine
		// emergency covers bit clock errors and power loss; PLL lock and over-rate flags do not trigger it
		emerg = !bck_valid || c_reg.pin_s2[3];
		target = emerg ? `DVR_CODE_MUTE : c_reg.vol;
		down = target > c_reg.cur;
		if (emerg) begin
			rate = c_reg.ramp_e[`DVR_DN_RATE_MSB:`DVR_DN_RATE_LSB];
			step = c_reg.ramp_e[`DVR_DN_STEP_MSB:`DVR_DN_STEP_LSB];
		end else if (down) begin
			rate = c_reg.ramp_n[`DVR_DN_RATE_MSB:`DVR_DN_RATE_LSB];
			step = c_reg.ramp_n[`DVR_DN_STEP_MSB:`DVR_DN_STEP_LSB];
		end else begin
			rate = c_reg.ramp_n[`DVR_UP_RATE_MSB:`DVR_UP_RATE_LSB];
			step = c_reg.ramp_n[`DVR_UP_STEP_MSB:`DVR_UP_STEP_LSB];
		end
		// step codes 00..11 give 8, 4, 2, 1 codes of 0.5 dB
		stepv = `DVR_STEP_BASE >> step;
		// rate codes 00..10 give a period of 1, 2 or 4 frames
		limit = 2'((3'h1 << rate) - 3'h1);
		diff = down ? (target - c_reg.cur) : (c_reg.cur - target);

		if (c_reg.cur == target) begin
			c_next.mode = dvr_pkg::RAMP_IDLE;
			c_next.tick_cnt = 2'h0;
		end else begin
			c_next.mode = emerg ? dvr_pkg::RAMP_EMERG : dvr_pkg::RAMP_NORMAL;
			if (rate == `DVR_RATE_INSTANT) begin
				// instant code jumps without waiting for a frame
				c_next.cur = target;
				c_next.tick_cnt = 2'h0;
			end else if (fs_tick) begin
				if (c_reg.tick_cnt >= limit) begin
					c_next.tick_cnt = 2'h0;
					// the last step is cut short so the code never overshoots
					if (diff <= stepv) begin
						c_next.cur = target;
					end else if (down) begin
						c_next.cur = c_reg.cur + stepv;
					end else begin
						c_next.cur = c_reg.cur - stepv;
					end
				end else begin
					c_next.tick_cnt = c_reg.tick_cnt + 2'h1;
				end
			end
		end

		// ========================================================
		// register writes; status bits 5..0 are read only
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				`DVR_OFS_CLKDET: begin
					c_next.resv = i_reg_wdata[7:6];
				end
				`DVR_OFS_VOL: begin
					c_next.vol = i_reg_wdata;
				end
				`DVR_OFS_RAMP_N: begin
					c_next.ramp_n = i_reg_wdata;
				end
				`DVR_OFS_RAMP_E: begin
					c_next.ramp_e = i_reg_wdata;
				end
				default: begin
					c_next.resv = c_reg.resv;
				end
			endcase
		end

		// register reads answer one cycle later; unmapped reads zero
		unique case (i_reg_addr)
			`DVR_OFS_CLKDET: rd_mux = {c_reg.resv, c_reg.status};
			`DVR_OFS_VOL: rd_mux = c_reg.vol;
			`DVR_OFS_RAMP_N: rd_mux = c_reg.ramp_n;
			`DVR_OFS_RAMP_E: rd_mux = c_reg.ramp_e;
			default: rd_mux = 8'h00;
		endcase
		if (i_reg_rd) begin
			c_next.rdata = rd_mux;
		end

		// ========================================================
		// synchronous reset
		if (i_sys_rst) begin
			c_next.vol = `DVR_RST_VOL;
			c_next.ramp_n = `DVR_RST_RAMP_N;
			c_next.ramp_e = `DVR_RST_RAMP_E;
			c_next.resv = 2'h0;
			c_next.status = 6'h00;
			c_next.rdata = 8'h00;
			c_next.cur = `DVR_RST_VOL;
			c_next.mode = dvr_pkg::RAMP_IDLE;
			c_next.tick_cnt = 2'h0;
			c_next.pin_s1 = 4'h0;
			c_next.pin_s2 = 4'h0;
			c_next.tick_s1 = 1'b0;
			c_next.tick_s2 = 1'b0;
			c_next.tick_s3 = 1'b0;
			c_next.act_s1 = 1'b0;
			c_next.act_s2 = 1'b0;
			c_next.act_s3 = 1'b0;
			c_next.miss_cnt = 8'h00;
			c_next.ratio_cur = 10'h000;
			c_next.ratio_prev = 10'h000;
			c_next.out_l = 24'h000000;
			c_next.out_r = 24'h000000;
			c_next.svalid = 1'b0;
		end
	end

	// core state registers
	always_ff @(posedge i_mclk) begin
		c_reg <= c_next;
	end

	// ============================================================
	// outputs, all from core flops
	assign o_reg_rdata = c_reg.rdata;
	assign o_volume_code = c_reg.cur;
	assign o_ramp_active = c_reg.mode != dvr_pkg::RAMP_IDLE;
	assign o_emergency = c_reg.mode == dvr_pkg::RAMP_EMERG;
	assign o_clock_fault_flags = c_reg.status;
	assign o_left_sample = c_reg.out_l;
	assign o_right_sample = c_reg.out_r;
	assign o_sample_valid = c_reg.svalid;

endmodule : dvr_volume_monitor

// [dvr_audio_source.sv]
// serial audio source model driving bit clock, frame clock and data
`timescale 1ns/1ps
module dvr_audio_source (
	input wire logic i_run,
	input wire logic [9:0] i_half,
	input wire logic [23:0] i_word,
	output logic o_bit_clock,
	output logic o_frame_clock,
	output logic o_audio_data
);
	int n;
	// idle levels at time zero
	initial begin
		o_bit_clock = 1'b1;
		o_frame_clock = 1'b1;
		o_audio_data = 1'b0;
	end
	// bit clock runs only while frames are sent, so a stop looks like a missing clock
	always begin
		if (!i_run) begin
			o_audio_data = ~o_audio_data;
			#15;
		end else begin
			for (n = 0; n < 2 * i_half; n++) begin
				#15 o_bit_clock = 1'b0;
				o_frame_clock = (n >= i_half);
				// past the word the line carries noise, never a held bit
				o_audio_data = (n % i_half < 24) ? i_word[23 - n % i_half] : 1'($urandom);
				#15 o_bit_clock = 1'b1;
			end
		end
	end
endmodule : dvr_audio_source

// [dvr_assertions.sv]
// checker on the ports of the volume ramp and clock monitor
`timescale 1ns/1ps
module dvr_assertions (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_pll_lock,
	input wire logic i_pll_enable,
	input wire logic i_pll_overrate,
	input wire logic i_fs_auto_mode,
	input wire logic i_fs_detect_valid,
	input wire logic i_fs_mismatch,
	input wire logic [7:0] o_volume_code,
	input wire logic o_ramp_active,
	input wire logic o_emergency,
	input wire logic [5:0] o_clock_fault_flags
);
	// ============================================================
	// copy of the target code, so a finished ramp can be held against it
	logic [7:0] tgt_reg;
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			tgt_reg <= 8'h30;
		else if (i_reg_wr && i_reg_addr == 8'h4C)
			tgt_reg <= i_reg_wdata;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// ============================================================
	// pins held long enough to cross the synchronisers
	sequence pll_held;
		$stable({i_pll_overrate, i_pll_lock, i_pll_enable}) [*6];
	endsequence
	sequence fs_held;
		$stable({i_fs_auto_mode, i_fs_detect_valid, i_fs_mismatch}) [*4];
	endsequence
	pll_over_a:
		assert property (pll_held |-> o_clock_fault_flags[4] == i_pll_overrate) else $error("pll over flag wrong");
	pll_lock_a:
		assert property (pll_held |-> o_clock_fault_flags[3] == (i_pll_lock & i_pll_enable)) else $error("lock flag wrong");
	fs_flag_a:
		assert property (fs_held |-> o_clock_fault_flags[0] == (i_fs_auto_mode ? i_fs_detect_valid : i_fs_mismatch))
			else $error("rate flag wrong");
	miss_rate_a:
		assert property (o_clock_fault_flags[2] |-> o_clock_fault_flags[5]) else $error("missing without rate flag");
	clk_valid_a:
		assert property (o_clock_fault_flags[1] |-> !o_clock_fault_flags[5] && !o_clock_fault_flags[2])
			else $error("valid clock beside a fault");
	emerg_down_a:
		assert property (o_emergency && $past(o_emergency) && $changed(o_volume_code)
			|-> o_volume_code > $past(o_volume_code)) else $error("emergency ramp raised gain");
	step_size_a:
		assert property (!o_emergency && !$past(o_emergency) && $changed(o_volume_code) && o_volume_code != tgt_reg
			|-> (o_volume_code - $past(o_volume_code) <= 8'h08) || ($past(o_volume_code) - o_volume_code <= 8'h08))
			else $error("ramp step too large");
	ramp_land_a:
		assert property ($fell(o_ramp_active) && !o_emergency && !$past(o_emergency) && !$past(i_reg_wr)
			|-> o_volume_code == tgt_reg) else $error("ramp stopped off target");
endmodule : dvr_assertions

bind dvr_volume_monitor dvr_assertions i_chk (.*);

// [dvr_volume_monitor_tb.sv]
// self-checking bench of the volume ramp and clock monitor
`timescale 1ns/1ps
module dvr_volume_monitor_tb;
	// ============================================================
	// signals and notes of expected results
	logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_power_loss = 1'b0;
	logic i_pll_lock = 1'b1, i_pll_enable = 1'b1, i_pll_overrate = 1'b0;
	logic i_fs_auto_mode = 1'b1, i_fs_detect_valid = 1'b1, i_fs_mismatch = 1'b0;
	logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_volume_code, last_code = 8'h30;
	logic [7:0] pulses = 8'h00, rv;
	logic i_bit_clock, i_frame_clock, i_audio_data, o_ramp_active, o_emergency, o_sample_valid;
	logic [5:0] o_clock_fault_flags;
	logic [23:0] o_left_sample, o_right_sample;
	logic run = 1'b1, trk = 1'b0, rd_d = 1'b0;
	logic [9:0] half = 10'h020;
	logic [7:0] q_rd[$];
	logic [15:0] q_vol[$];
	int num_errors = 0, comparisons = 0, i;
	dvr_audio_source i_src (.i_run(run), .i_half(half), .i_word(24'hC35A96), .o_bit_clock(i_bit_clock),
		.o_frame_clock(i_frame_clock), .o_audio_data(i_audio_data));
	dvr_volume_monitor i_dut (.*);
	// system clock, 25 ns period
	always #12.5 i_mclk = ~i_mclk;
	// ============================================================
	// shared tasks
	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_reg_wr <= w;
		i_reg_rd <= ~w;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
	endtask : bus
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		q_rd.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd_exp
	// status byte from rate, missing and valid bits; bits 7:6 were written as ones
	function automatic logic [7:0] st(input logic [2:0] m);
		return {2'h3, m[2], i_pll_overrate, i_pll_lock & i_pll_enable, m[1:0], i_fs_auto_mode ? i_fs_detect_valid : i_fs_mismatch};
	endfunction : st
	// let a ramp start, then wait until it settles
	task automatic idle();
		repeat (8) @(posedge i_mclk);
		repeat (40000) if (o_ramp_active !== 1'b0) @(posedge i_mclk);
		repeat (2) @(posedge i_mclk);
	endtask : idle
	// note every code the ramp must pass, then start it by a write or by power loss
	task automatic ramp(input logic [7:0] r, input logic [7:0] adr, input logic [7:0] tgt);
		logic [3:0] f;
		logic [7:0] s, cur, p;
		idle();
		cur = o_volume_code;
		f = (tgt > cur) ? r[7:4] : r[3:0];
		s = 8'h08 >> f[1:0];
		p = 8'h00;
		while (cur != tgt) begin
			cur = (f[3:2] == 2'h3 || (tgt > cur ? tgt - cur : cur - tgt) <= s) ? tgt : (tgt > cur ? cur + s : cur - s);
			q_vol.push_back({p, cur});
			p = 8'h01 << f[3:2];
		end
		trk = 1'b1;
		bus(1'b1, adr, r);
		if (adr == 8'h4F)
			i_power_loss <= 1'b1;
		else
			bus(1'b1, 8'h4C, tgt);
		idle();
		check("pending", 24'(q_vol.size()), 24'h0);
		trk = 1'b0;
	endtask : ramp
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// ============================================================
	// compare each read and each tracked code move with the oldest note; frames counted in between
	always @(posedge i_mclk) begin
		logic [15:0] e;
		rd_d <= i_reg_rd;
		if (rd_d === 1'b1) check("rdata", 24'(o_reg_rdata), 24'(q_rd.pop_front()));
		if (trk && o_volume_code !== last_code) begin
			e = q_vol.pop_front();
			check("code", 24'(o_volume_code), 24'(e[7:0]));
			if (e[15:8] != 8'h00) check("frames", 24'(pulses + 8'(o_sample_valid)), 24'(e[15:8]));
			check("emergency", 24'(o_emergency), 24'(i_power_loss));
			pulses <= 8'h00;
		end else if (o_sample_valid === 1'b1)
			pulses <= pulses + 8'h01;
		// samples leave zeroed while the code in force at the frame was mute
		if (trk && o_sample_valid === 1'b1) begin
			check("left", o_left_sample, (last_code == 8'hFF) ? 24'h000000 : 24'hC35A96);
			check("right", o_right_sample, (last_code == 8'hFF) ? 24'h000000 : 24'hC35A96);
		end
		last_code <= o_volume_code;
	end
	// main sequence: reset values, status pins, ramps, emergency, clock faults
	initial begin
		void'($urandom(44));
		repeat (4) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rd_exp(8'h4C, 8'h30);
		rd_exp(8'h4E, 8'h33);
		rd_exp(8'h4F, 8'h30);
		bus(1'b1, 8'h4D, 8'h5A);
		rd_exp(8'h4D, 8'h00);
		bus(1'b1, 8'h39, 8'hFF);
		repeat (400) @(posedge i_mclk);
		for (i = 0; i < 8; i++) begin
			{i_pll_lock, i_pll_enable, i_pll_overrate, i_fs_auto_mode, i_fs_detect_valid, i_fs_mismatch} <= 6'($urandom);
			repeat (8) @(posedge i_mclk);
			rd_exp(8'h39, st(3'h1));
		end
		// every rate code down and up; of the steps used only 1 code divides the distance
		for (i = 0; i < 4; i++) begin
			rv = {i[1:0], i[1:0], i[1:0], ~i[1:0]};
			ramp(rv, 8'h4E, 8'h43);
			ramp(rv, 8'h4E, 8'h30);
		end
		ramp(8'h50, 8'h4F, 8'hFF);
		i_power_loss <= 1'b0;
		ramp(8'hC0, 8'h4F, 8'hFF);
		i_power_loss <= 1'b0;
		idle();
		half <= 10'h008;
		repeat (600) @(posedge i_mclk);
		rd_exp(8'h39, st(3'h4));
		run <= 1'b0;
		repeat (200) @(posedge i_mclk);
		rd_exp(8'h39, st(3'h6));
		report_and_stop();
	end
	// cut a hang short well past the expected run length
	initial begin
		#2000000;
		num_errors++;
		report_and_stop();
	end
endmodule : dvr_volume_monitor_tb
